// *** src/clkdrv_pkg.sv ***
// Purpose: Shared constants for the clock output divider block
// Assumes: AXI4-Lite register access, 32-bit data, 20 MHz aclk
// Notes: Offsets are byte addresses of aligned words
package clkdrv_pkg;
	// Register byte offsets
	localparam logic [3:0] CTRL_OFFSET   = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [3:0] PERIOD_OFFSET = 4'h8;
	// Control field positions
	localparam int CTRL_LOOP_BIT     = 0;
	localparam int CTRL_RANGE_BIT    = 1;
	localparam int CTRL_POLARITY_BIT = 2;
	localparam int CTRL_REFSEL_BIT   = 3;
	localparam int CTRL_FB_LSB       = 4;
	localparam int CTRL_WIDTH        = 6;
	// Control reset value: test mode, all fields low
	localparam logic [5:0] CTRL_RESET = 6'h00;
	// Status field positions
	localparam int STAT_LOCK_BIT   = 0;
	localparam int STAT_ENABLE_BIT = 1;
	localparam int STAT_DOUBLE_BIT = 2;
	localparam int STAT_BASE_BIT   = 3;
	localparam int STAT_HALF_BIT   = 4;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Divider chain states at an aligned reference edge
	localparam logic [2:0] CHAIN_ALL_HIGH = 3'h7;
	localparam logic [2:0] CHAIN_ALL_LOW  = 3'h0;
	// Loop steps per reference period, as shift counts
	localparam logic [1:0] SHIFT_DOUBLE = 2'h1;
	localparam logic [1:0] SHIFT_BASE   = 2'h2;
	localparam logic [1:0] SHIFT_HALF   = 2'h3;
	// Aligned edges needed before lock is reported
	localparam logic [1:0] LOCK_EDGES = 2'h2;
	// Feedback source encodings
	typedef enum logic [1:0] {
		FB_HALF, FB_BASE, FB_INVERTED, FB_DOUBLE
	} fb_source_t;
endpackage : clkdrv_pkg

// *** src/level_sync.sv ***
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are levels slower than aclk
// Notes: First stage is read only by the second stage
module level_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1; // Metastability catcher

	// Two stages, reset to low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : level_sync

// *** src/pll_clock_output_divider.sv ***
// Purpose: Digital output generation of a zero-delay clock driver
// Assumes: Reference clocks well below aclk/4; modelled by sampling
// Notes: Loop mode is a digital period tracker, not an analog loop
// Behaviour
// [R1] Loop off: dividers run from selected reference
// [R2] Test, range high: double output inverts reference
// [R3] Test, range high: base outputs divide by two
// [R4] Test, range high: half output divides by four
// [R5] Test, range low: divide by two, four, eight
// [R6] Loop mode: feedback output matches reference frequency
// [R7] Double feedback: base half, half quarter rate
// [R8] Base feedback: half half-rate, double twice
// [R9] Half feedback: base twice, double four times
// [R10] Polarity picks falling or rising edge alignment
// [R11] Enable low clears dividers, tri-states outputs
// [R12] All outputs come from one divider chain; the range-high test double is the inverted reference
//
// Chosen here: the register addresses and register access over AXI4-Lite.
module pll_clock_output_divider
	import clkdrv_pkg::*;
#(
	parameter int PERIOD_W = 16
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Reference and enable pins
	input  wire logic        reference_clock_a,
	input  wire logic        reference_clock_b,
	input  wire logic        output_enable_n_clear,
	// Clock outputs with enables
	output logic             double_rate_out,
	output logic             double_rate_oe,
	output logic [4:0]       base_rate_outs,
	output logic [4:0]       base_rate_oe,
	output logic             inverted_base_out,
	output logic             inverted_base_oe,
	output logic             half_rate_out,
	output logic             half_rate_oe
);
	logic [CTRL_WIDTH-1:0] ctrl;         // Control register
	logic [2:0]            pins;         // Synchronised pin levels
	logic                  ref_prev;     // Reference one cycle ago
	logic                  ref_now;      // Selected reference level
	logic                  fall_edge;    // Reference falling edge
	logic                  align_edge;   // Chosen aligned edge
	logic                  enabled;      // Outputs enabled
	logic                  loop_on;      // Loop engaged
	logic                  range_hi;     // Range select high
	logic                  fb_inv;       // Inverted output is feedback
	fb_source_t            fb_src;       // Feedback source
	logic [2:0]            chain;        // Common divider chain
	logic                  tap_invert;   // Read chain as a down count
	logic [2:0]            fb_mask;      // Chain bits up to feedback tap
	logic [PERIOD_W-1:0]   period_cnt;   // Cycles since aligned edge
	logic [PERIOD_W-1:0]   period;       // Measured reference period
	logic [PERIOD_W-1:0]   step_len;     // Cycles per chain step
	logic [PERIOD_W-1:0]   step_cnt;     // Cycles into current step
	logic [1:0]            step_shift;   // Steps per period as shift
	logic [1:0]            edge_count;   // Aligned edges seen
	logic                  locked;       // Period tracked twice
	logic                  next_double;  // Double output next value
	logic                  next_base;    // Base output next value
	logic                  next_half;    // Half output next value
	logic                  aw_held;      // Write address captured
	logic                  w_held;       // Write data captured
	logic [3:0]            aw_addr;      // Captured write address
	logic [31:0]           w_data;       // Captured write data
	logic [3:0]            w_strb;       // Captured write strobes

	// Pins cross into aclk through two flops
	level_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({output_enable_n_clear, reference_clock_b, reference_clock_a}),
		.sync_out (pins)
	);

	// Decode control and select reference
	always_comb begin
		loop_on    = ctrl[CTRL_LOOP_BIT];
		range_hi   = ctrl[CTRL_RANGE_BIT];
		fb_src     = fb_source_t'(ctrl[CTRL_FB_LSB +: 2]);
		fb_inv     = (fb_src == FB_INVERTED);
		enabled    = pins[2];
		ref_now    = ctrl[CTRL_REFSEL_BIT] ? pins[1] : pins[0];
		fall_edge  = ref_prev && !ref_now;
		// Polarity high aligns on falling edges, else rising
		align_edge = ctrl[CTRL_POLARITY_BIT] ? fall_edge : (!ref_prev && ref_now); // [R10]
		// Rising alignment needs a down count; inverted feedback swaps it
		tap_invert = loop_on && !(ctrl[CTRL_POLARITY_BIT] ^ fb_inv); // [R10]
	end

	// Steps per reference period follow the fed-back output
	always_comb begin
		case (fb_src)
			FB_DOUBLE: step_shift = SHIFT_DOUBLE; // [R7]
			FB_HALF:   step_shift = SHIFT_HALF;   // [R9]
			default:   step_shift = SHIFT_BASE;   // [R8]
		endcase
		step_len = period >> step_shift;
		// Bits up to the fed-back tap wrap only at an aligned edge
		fb_mask  = 3'((4'h1 << step_shift) - 4'h1);
		// Guard against a zero step on very fast references
		if (step_len == '0) begin
			step_len = {{(PERIOD_W-1){1'b0}}, 1'b1};
		end
	end

	// Previous reference level for edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_prev <= 1'b0;
		end else begin
			ref_prev <= ref_now;
		end
	end

	// Reference period measurement between aligned edges
	always_ff @(posedge aclk) begin
		if (!aresetn || !enabled || !loop_on) begin
			period_cnt <= '0;
			period     <= '0;
			edge_count <= '0;
		end else if (align_edge) begin
			period_cnt <= '0;
			period     <= period_cnt + 1'b1;
			if (edge_count != LOCK_EDGES) begin
				edge_count <= edge_count + 1'b1;
			end
		end else if (period_cnt != '1) begin
			period_cnt <= period_cnt + 1'b1;
		end
	end

	// Lock once one full period has been measured, after two aligned edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			locked <= 1'b0;
		end else begin
			locked <= loop_on && enabled && (edge_count == LOCK_EDGES);
		end
	end

	// Common divider chain for every output but the range-high test double
	always_ff @(posedge aclk) begin
		if (!aresetn || !enabled) begin
			chain    <= '0; // [R11]
			step_cnt <= '0;
		end else if (!loop_on) begin
			// Test mode steps on each falling reference edge
			step_cnt <= '0;
			if (fall_edge) begin
				chain <= chain + 1'b1; // [R1] [R3]
			end
		end else if (align_edge) begin
			// Fed-back tap and faster bits wrap, slower ones carry
			chain    <= (chain | fb_mask) + 3'h1; // [R6] [R10]
			step_cnt <= '0;
		end else if (step_cnt >= step_len - 1'b1) begin
			// Stall below the wrap: a fast step never carries early
			chain    <= ((chain & fb_mask) == fb_mask) ? chain : chain + 1'b1; // [R6] [R12]
			step_cnt <= '0;
		end else begin
			step_cnt <= step_cnt + 1'b1;
		end
	end

	// Output taps from the chain, double from the reference in range-high test
	always_comb begin
		if (!loop_on && range_hi) begin
			next_double = !ref_now;  // [R2]
			next_base   = chain[0];  // [R3]
			next_half   = chain[1];  // [R4]
		end else begin
			// Loop mode and low-range test share one tapping, loop may invert
			next_double = chain[0] ^ tap_invert;  // [R5] [R7]
			next_base   = chain[1] ^ tap_invert;  // [R5] [R8]
			next_half   = chain[2] ^ tap_invert;  // [R5] [R9]
		end
	end

	// Registered outputs and enables
	always_ff @(posedge aclk) begin
		if (!aresetn || !enabled) begin
			double_rate_out   <= 1'b0; // [R11]
			base_rate_outs    <= '0;
			inverted_base_out <= 1'b0;
			half_rate_out     <= 1'b0;
			double_rate_oe    <= 1'b0;
			base_rate_oe      <= '0;
			inverted_base_oe  <= 1'b0;
			half_rate_oe      <= 1'b0;
		end else begin
			double_rate_out   <= next_double;
			base_rate_outs    <= {5{next_base}}; // [R12]
			inverted_base_out <= !next_base;
			half_rate_out     <= next_half;
			double_rate_oe    <= 1'b1; // [R11]
			base_rate_oe      <= '1;
			inverted_base_oe  <= 1'b1;
			half_rate_oe      <= 1'b1;
		end
	end

	// Write address channel: hold one address until answered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			aw_addr       <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awready && s_axi_awvalid) begin
			aw_held       <= 1'b1;
			aw_addr       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held       <= 1'b0;
			s_axi_awready <= 1'b1;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_bvalid;
		end
	end

	// Write data channel: hold one word until answered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held       <= 1'b0;
			w_data       <= '0;
			w_strb       <= '0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wready && s_axi_wvalid) begin
			w_held       <= 1'b1;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_held       <= 1'b0;
			s_axi_wready <= 1'b1;
		end else begin
			s_axi_wready <= !w_held && !s_axi_bvalid;
		end
	end

	// Register write and response once both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl         <= CTRL_RESET;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (s_axi_bvalid) begin
			if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end else if (aw_held && w_held) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr == CTRL_OFFSET) begin
				s_axi_bresp <= RESP_OKAY;
				// Only the low byte holds control fields
				if (w_strb[0]) begin
					ctrl <= w_data[CTRL_WIDTH-1:0];
				end
			end else if (aw_addr == STATUS_OFFSET || aw_addr == PERIOD_OFFSET) begin
				// Read-only words accept and drop writes
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end
	end

	// Read channel: one outstanding read, answered next cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rdata   <= '0;
			case (s_axi_araddr)
				CTRL_OFFSET: begin
					s_axi_rdata[CTRL_WIDTH-1:0] <= ctrl;
				end
				STATUS_OFFSET: begin
					s_axi_rdata[STAT_LOCK_BIT]   <= locked;
					s_axi_rdata[STAT_ENABLE_BIT] <= enabled;
					s_axi_rdata[STAT_DOUBLE_BIT] <= double_rate_out;
					s_axi_rdata[STAT_BASE_BIT]   <= base_rate_outs[0];
					s_axi_rdata[STAT_HALF_BIT]   <= half_rate_out;
				end
				PERIOD_OFFSET: begin
					s_axi_rdata[PERIOD_W-1:0] <= period;
				end
				default: begin
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule : pll_clock_output_divider

// *** tb/pll_clock_output_divider_properties.sv ***
// Purpose: Port checks of the clock output divider
// Assumes: Range-high test double lags reference pins by 3 aclk, chain taps by 4
// Notes: Control is shadowed from completed bus writes
module divider_checker
	import clkdrv_pkg::*;
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write traffic
	input wire logic [3:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// Pins
	input wire logic        reference_clock_a,
	input wire logic        reference_clock_b,
	input wire logic        output_enable_n_clear,
	input wire logic        double_rate_out,
	input wire logic        double_rate_oe,
	input wire logic [4:0]  base_rate_outs,
	input wire logic [4:0]  base_rate_oe,
	input wire logic        inverted_base_out,
	input wire logic        inverted_base_oe,
	input wire logic        half_rate_out,
	input wire logic        half_rate_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wa;   // Last write address
	logic [5:0] wd;   // Last write data
	logic       ws;   // Low byte strobe
	logic [5:0] ctrl; // Control shadow
	logic [3:0] q;    // Quiet cycles
	logic       sref; // Selected reference
	logic       thi;  // Settled test, range high
	logic       tlo;  // Settled test, range low
	assign sref = ctrl[CTRL_REFSEL_BIT] ? reference_clock_b : reference_clock_a;
	assign thi = q == 4'hf && !ctrl[CTRL_LOOP_BIT] && ctrl[CTRL_RANGE_BIT];
	assign tlo = q == 4'hf && !ctrl[CTRL_LOOP_BIT] && !ctrl[CTRL_RANGE_BIT];
	// Commit at the response, when both halves are surely in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RESET;
			wa <= 4'h0;
			wd <= 6'h00;
			ws <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[5:0];
			if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
			if (s_axi_bvalid && s_axi_bready && wa == CTRL_OFFSET && ws) ctrl <= wd;
		end
	end
	// Any write or clear restarts it: mode changes land before the shadow
	always_ff @(posedge aclk) begin
		if (!aresetn || !output_enable_n_clear || s_axi_wvalid) q <= 4'h0;
		else if (q != 4'hf) q <= q + 4'h1;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_oe_off;
		!output_enable_n_clear [*4] |-> {double_rate_oe, base_rate_oe, inverted_base_oe, half_rate_oe,
			double_rate_out, base_rate_outs, inverted_base_out, half_rate_out} == 16'h0000;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("driven while cleared");
	property p_oe_on;
		output_enable_n_clear [*5] |-> {double_rate_oe, base_rate_oe, inverted_base_oe, half_rate_oe} == 8'hff;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("not driven when enabled");
	property p_inv;
		q == 4'hf |-> inverted_base_out != base_rate_outs[0];
	endproperty
	a_inv: assert property (p_inv) else $error("inverted output not inverse");
	property p_same;
		base_rate_outs == {5{base_rate_outs[0]}};
	endproperty
	a_same: assert property (p_same) else $error("base outputs differ");
	property p_hi_double;
		thi |-> double_rate_out == !$past(sref, 3);
	endproperty
	a_hi_double: assert property (p_hi_double) else $error("double not inverse");
	property p_hi_base;
		thi |-> $changed(base_rate_outs[0]) == ($past(sref, 5) && !$past(sref, 4));
	endproperty
	a_hi_base: assert property (p_hi_base) else $error("base off falling edge");
	property p_hi_half;
		thi && $changed(half_rate_out) |-> $changed(base_rate_outs[0]);
	endproperty
	a_hi_half: assert property (p_hi_half) else $error("half off chain");
	property p_lo_double;
		tlo |-> $changed(double_rate_out) == ($past(sref, 5) && !$past(sref, 4));
	endproperty
	a_lo_double: assert property (p_lo_double) else $error("double off falling edge");
	property p_lo_base;
		tlo && ($changed(base_rate_outs[0]) || $changed(half_rate_out)) |-> $changed(double_rate_out);
	endproperty
	a_lo_base: assert property (p_lo_base) else $error("low range chain broken");
	c_hi: cover property (thi && $changed(half_rate_out));
	c_lo: cover property (tlo && $changed(half_rate_out));
	c_off: cover property (!double_rate_oe ##1 double_rate_oe);
endmodule : divider_checker

bind pll_clock_output_divider divider_checker chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.reference_clock_a, .reference_clock_b, .output_enable_n_clear, .double_rate_out, .double_rate_oe,
	.base_rate_outs, .base_rate_oe, .inverted_base_out, .inverted_base_oe, .half_rate_out, .half_rate_oe);

// *** tb/ref_clock_source.sv ***
// Purpose: Two free-running reference clocks
// Assumes: Half periods of at least three aclk cycles
// Notes: Edges land just after aclk edges
module ref_clock_source (
	// Clock
	input wire logic       aclk,
	// Half periods in aclk cycles
	input wire logic [7:0] half_a,
	input wire logic [7:0] half_b,
	// Reference pins
	output logic           ref_a = 1'b0,
	output logic           ref_b = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_a = 8'h00; // Cycles in level a
	logic [7:0] cnt_b = 8'h00; // Cycles in level b
	// Each level toggles after its half period
	always @(posedge aclk) begin
		cnt_a <= (cnt_a + 8'h01 >= half_a) ? 8'h00 : cnt_a + 8'h01;
		cnt_b <= (cnt_b + 8'h01 >= half_b) ? 8'h00 : cnt_b + 8'h01;
		if (cnt_a + 8'h01 >= half_a) ref_a <= !ref_a;
		if (cnt_b + 8'h01 >= half_b) ref_b <= !ref_b;
	end
endmodule : ref_clock_source

// *** tb/tb_pll_clock_output_divider.sv ***
// Purpose: Self-checking bench of the clock output divider
// Assumes: Loop mode tracks a 64-cycle reference
// Notes: Rates are judged by edge counts, one edge of slack
module tb_pll_clock_output_divider
	import clkdrv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0, aresetn = 1'b0, output_enable_n_clear = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, rd;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] half_a = 8'h08, half_b = 8'h10; // Reference half periods
	logic reference_clock_a, reference_clock_b, double_rate_out, double_rate_oe;
	logic inverted_base_out, inverted_base_oe, half_rate_out, half_rate_oe;
	logic [4:0] base_rate_outs, base_rate_oe;
	int n_fail = 0, n_checks = 0;
	initial begin
		forever #25 aclk = ~aclk;
	end
	ref_clock_source src_u (.aclk, .half_a, .half_b, .ref_a(reference_clock_a), .ref_b(reference_clock_b));
	pll_clock_output_divider dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.reference_clock_a, .reference_clock_b, .output_enable_n_clear, .double_rate_out, .double_rate_oe,
		.base_rate_outs, .base_rate_oe, .inverted_base_out, .inverted_base_oe, .half_rate_out, .half_rate_oe);
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("mismatch at %0t got %h expected %h", $time, g, e);
			n_fail++;
		end
	endtask : chk
	// A spent wait bound ends the run
	task guard(input int i);
		if (i >= 400) chk(32'(i), 32'h0);
		if (i >= 400) tally_and_finish;
	endtask : guard
	function automatic logic [15:0] pins();
		return {double_rate_oe, base_rate_oe, inverted_base_oe, half_rate_oe,
			double_rate_out, base_rate_outs, inverted_base_out, half_rate_out};
	endfunction : pins
	task axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 400; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		guard(i);
		chk(32'(s_axi_bresp), 32'(e));
		s_axi_bready <= 1'b0;
	endtask : axi_write
	task axi_read(input logic [3:0] a, input logic [1:0] e);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 400; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		guard(i);
		rd = s_axi_rdata;
		chk(32'(s_axi_rresp), 32'(e));
		s_axi_rready <= 1'b0;
	endtask : axi_read
	// Counts rising edges of reference, double, base and half outputs
	task measure(input logic s, input int cyc, input int er, input int ed, input int eb, input int eh);
		int i, j;
		int c[4];
		int e[4];
		logic [3:0] p, v;
		c = '{0, 0, 0, 0};
		e = '{eh, eb, ed, er};
		p = 4'h0;
		for (i = 0; i <= cyc; i++) begin
			@(posedge aclk);
			v = {s ? reference_clock_b : reference_clock_a, double_rate_out, base_rate_outs[0], half_rate_out};
			for (j = 0; j < 4; j++) if (i > 0 && v[j] && !p[j]) c[j]++;
			p = v;
		end
		for (j = 0; j < 4; j++) chk(32'(((c[j] - e[j]) inside {[-1:1]}) ? e[j] : c[j]), 32'(e[j]));
	endtask : measure
	// Fed-back and faster outputs sit at their aligned level just after the edge; m masks them, x is that level
	task loop_run(input logic [31:0] c, input int ed, input int eb, input int eh, input logic [15:0] m,
		input logic [15:0] x);
		int i;
		axi_write(CTRL_OFFSET, c, RESP_OKAY);
		repeat (384) @(posedge aclk);
		axi_read(STATUS_OFFSET, RESP_OKAY);
		chk(rd & 32'h3, 32'h3);
		axi_read(PERIOD_OFFSET, RESP_OKAY);
		chk(rd, 32'd64);
		measure(1'b0, 512, 8, ed, eb, eh);
		for (i = 0; i < 400 && reference_clock_a !== c[CTRL_POLARITY_BIT]; i++) @(posedge aclk);
		for (; i < 400 && reference_clock_a === c[CTRL_POLARITY_BIT]; i++) @(posedge aclk);
		guard(i);
		repeat (5) @(posedge aclk);
		chk(32'(pins() & m), 32'(x));
	endtask : loop_run
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(CTRL_OFFSET, RESP_OKAY);
		chk(rd, 32'(CTRL_RESET));
		axi_read(4'hc, RESP_SLVERR);
		chk(32'(pins()), 32'h0);
		output_enable_n_clear <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(32'(pins() >> 8), 32'hff);
		measure(1'b0, 256, 16, 8, 4, 2);
		axi_write(CTRL_OFFSET, 32'h2, RESP_OKAY);
		measure(1'b0, 256, 16, 16, 8, 4);
		axi_write(CTRL_OFFSET, 32'ha, RESP_OKAY);
		measure(1'b1, 256, 8, 8, 4, 2);
		axi_write(STATUS_OFFSET, 32'h0, RESP_OKAY);
		axi_read(CTRL_OFFSET, RESP_OKAY);
		chk(rd, 32'ha);
		output_enable_n_clear <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(32'(pins()), 32'h0);
		output_enable_n_clear <= 1'b1;
		half_a <= 8'h20;
		loop_run(32'h31, 8, 4, 2, 16'h0080, 16'h0080);
		loop_run(32'h11, 16, 8, 4, 16'h00fe, 16'h00fc);
		loop_run(32'h01, 32, 16, 8, 16'h00ff, 16'h00fd);
		loop_run(32'h35, 8, 4, 2, 16'h0080, 16'h0000);
		loop_run(32'h25, 16, 8, 4, 16'h00fe, 16'h00fc);
		tally_and_finish;
	end
endmodule : tb_pll_clock_output_divider
